//--- dv/tb_top.sv
// Self-checking bench of the touch-screen serial sequencer
`timescale 1ns/1ps
`include "tsq_map.vh"
module tb_top;
    logic mclk, rst, pen_touched, result_ready, clk_en;
    logic [11:0] target; // Analog value seen by the stand-in comparator
    wire chip_select_n, serial_clock, serial_in, comp_above, serial_out, serial_out_oe, busy, busy_oe;
    wire pen_touch_irq_n_o, pen_touch_irq_n_oe, drv_x_high, drv_x_low, drv_y_high, drv_y_low;
    wire adc_powered, sample_hold, result_valid, result_room, result_dropped;
    wire [2:0] adc_pos_sel;
    wire [1:0] adc_ref_sel;
    wire [11:0] sar_trial;
    wire [15:0] result_data;
    int errors, total_checks;
    // Ideal comparator standing in for the analog front end
    assign comp_above = (target >= sar_trial);
    tsq_host_model h (.mclk, .chip_select_n, .serial_clock, .serial_in);
    tsq_serial_seq uut (.mclk, .rst, .clk_en, .chip_select_n, .serial_clock, .serial_in, .comp_above,
        .pen_touched, .result_ready, .serial_out, .serial_out_oe, .busy, .busy_oe, .pen_touch_irq_n_o,
        .pen_touch_irq_n_oe, .drv_x_high, .drv_x_low, .drv_y_high, .drv_y_low, .adc_pos_sel, .adc_ref_sel,
        .adc_powered, .sample_hold, .sar_trial, .result_valid, .result_data, .result_room, .result_dropped);
    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One frame: lead zeros, control byte, decisions, optional overlapped second byte
    task automatic do_conv(input logic [7:0] c, input logic [7:0] nx, input int lead, input logic [2:0] sel,
                           input logic [1:0] rf, input logic [3:0] drv, input logic chk);
        int n;
        int last;
        logic e;
        logic [7:0] cc;
        n = c[3] ? 8 : 12;
        last = (nx != 8'h00) ? 38 : 23;
        h.sel(1'b1);
        for (int i = 0; i < lead; i++) h.clk_bit(1'b0);
        check("enables", {serial_out_oe, busy_oe, busy}, 3'b110);
        check("pen masked", pen_touch_irq_n_oe, 1'b0);
        for (int i = 0; i <= last; i++) begin
            h.clk_bit(i < 8 ? c[7 - i] : (i >= 15 && i < 23) ? nx[22 - i] : 1'b0);
            check("busy", busy, (i == 7) || (nx != 8'h00 && i == 22));
            e = 1'b0;
            if (i >= 8 && i < 8 + n) e = target[19 - i];
            if (nx != 8'h00 && i >= 23 && i < 35) e = target[34 - i];
            check("serial_out", serial_out, e);
            if (i == 5) check("acquire", {drv_x_high, drv_x_low, drv_y_high, drv_y_low, adc_pos_sel, adc_ref_sel},
                              {drv, sel, `TSQ_REF_EXT});
            if (i == 10) check("convert", {drv_x_high, drv_x_low, drv_y_high, drv_y_low, adc_pos_sel, adc_ref_sel},
                               {(c[2] ? 4'h0 : drv), sel, rf});
        end
        h.sel(1'b0);
        cc = (nx != 8'h00) ? nx : c;
        check("released", {serial_out_oe, busy_oe}, 2'b00);
        check("pen", pen_touch_irq_n_oe, cc[1:0] == `TSQ_PM_AUTO_OFF);
        for (int k = 0; k < ((nx != 8'h00) ? 2 : 1); k++) begin
            for (int w = 0; w < 20 && !result_valid; w++) @(negedge mclk);
            if (!result_valid) begin
                errors++;
                give_verdict();
            end
            cc = k ? nx : c;
            if (chk) check("result", result_data, {cc[3], cc[6:4], target});
            if (k == 0) begin
                // A pop offered while frozen must not take the word
                clk_en = 1'b0;
                result_ready = 1'b1;
                @(negedge mclk);
                result_ready = 1'b0;
                clk_en = 1'b1;
                @(negedge mclk);
                check("frozen", result_valid, 1'b1);
            end
            result_ready = 1'b1;
            @(negedge mclk);
            result_ready = 1'b0;
            @(negedge mclk);
        end
        check("drained", result_valid, 1'b0);
    endtask
    task automatic t_single;
        target = 12'hA5C;
        do_conv(8'h94, 8'h00, 16, `TSQ_SEL_XH, `TSQ_REF_EXT, 4'h3, 1'b1);
        do_conv(8'hE5, 8'h00, 0, `TSQ_SEL_AUXB, `TSQ_REF_EXT, 4'h0, 1'b1);
        do_conv(8'h84, 8'h00, 1, `TSQ_SEL_NONE, `TSQ_REF_EXT, 4'h0, 1'b0);
        $display("single-ended test done");
    endtask
    task automatic t_diff;
        target = 12'h3C7;
        do_conv(8'hD0, 8'h00, 0, `TSQ_SEL_YH, `TSQ_REF_XPLATE, 4'hC, 1'b1);
        do_conv(8'h90, 8'h00, 3, `TSQ_SEL_XH, `TSQ_REF_YPLATE, 4'h3, 1'b1);
        $display("differential test done");
    endtask
    task automatic t_short;
        target = 12'h6B0;
        do_conv(8'hAC, 8'h00, 2, `TSQ_SEL_AUXA, `TSQ_REF_EXT, 4'h0, 1'b0);
        $display("eight-bit test done");
    endtask
    task automatic t_overlap;
        target = 12'h801;
        do_conv(8'h94, 8'h94, 0, `TSQ_SEL_XH, `TSQ_REF_EXT, 4'h3, 1'b1);
        $display("overlap test done");
    endtask
    // Deselect mid-conversion, then clock a deselected link
    task automatic t_abort;
        logic [7:0] ctl;
        ctl = 8'h94;
        h.sel(1'b1);
        for (int i = 0; i < 12; i++) h.clk_bit(i < 8 ? ctl[7 - i] : 1'b0);
        check("powered", adc_powered, 1'b1);
        h.sel(1'b0);
        check("abort", {busy, serial_out, adc_powered, serial_out_oe}, 4'h0);
        for (int i = 0; i < 8; i++) h.clk_bit(1'b1);
        check("ignored", {busy_oe, result_valid}, 2'b00);
        $display("abort test done");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        pen_touched = 1'b0;
        result_ready = 1'b0;
        target = 12'h000;
        clk_en = 1'b1;
        errors = 0;
        total_checks = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        check("reset", {busy, serial_out_oe, result_valid, result_room, pen_touch_irq_n_oe}, 5'b00010);
        pen_touched = 1'b1;
        repeat (3) @(negedge mclk);
        check("pen idle", pen_touch_irq_n_oe, 1'b1);
        t_single();
        t_diff();
        t_short();
        t_overlap();
        t_abort();
        pen_touched = 1'b0;
        repeat (3) @(negedge mclk);
        check("pen released", pen_touch_irq_n_oe, 1'b0);
        pen_touched = 1'b1;
        t_single();
        give_verdict();
    end
endmodule // tb_top

//--- dv/tsq_host_model.sv
// Host serial master model: mode-0 clocking, select and data lines
`timescale 1ns/1ps
module tsq_host_model (
    input wire logic mclk,
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_in
);
    // About 62 mclk per half period keeps the link just under 2 MHz
    localparam int HALF = 62;
    // Idle levels: deselected, clock low
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    // Select or release; a released data line never keeps its last value
    task automatic sel(input logic on);
        @(negedge mclk);
        chip_select_n = ~on;
        if (!on) begin
            serial_in = ~serial_in;
        end
        repeat (HALF) @(negedge mclk);
    endtask
    // One bit: data set while low, rise samples it, fall shifts out
    task automatic clk_bit(input logic b);
        @(negedge mclk);
        serial_in = b;
        repeat (HALF) @(negedge mclk);
        serial_clock = 1'b1;
        repeat (HALF) @(negedge mclk);
        serial_clock = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
endmodule // tsq_host_model

//--- dv/tsq_serial_seq_assertions.sv
// Port-level checks of the touch-screen serial sequencer
`timescale 1ns/1ps
module tsq_serial_seq_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic pen_touched,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic busy,
    input wire logic busy_oe,
    input wire logic pen_touch_irq_n_o,
    input wire logic pen_touch_irq_n_oe,
    input wire logic drv_x_high,
    input wire logic drv_x_low,
    input wire logic drv_y_high,
    input wire logic drv_y_low,
    input wire logic adc_powered
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_oe_pair: assert property (serial_out_oe == busy_oe)
        else $error("Output enables disagree");
    a_oe_released: assert property (chip_select_n [*2] |-> !serial_out_oe)
        else $error("Output driven while deselected");
    a_abort_quiet: assert property ($rose(chip_select_n) |-> ##2 (!busy && !serial_out && !adc_powered))
        else $error("Deselect did not abort");
    a_pen_open_drain: assert property (!pen_touch_irq_n_o)
        else $error("Pen line driven high");
    a_pen_cause: assert property (pen_touch_irq_n_oe |-> $past(pen_touched) || $past(pen_touched, 2))
        else $error("Pen line pulled without touch");
    a_pen_masked: assert property ($fell(chip_select_n) |-> ##2 !pen_touch_irq_n_oe)
        else $error("Pen line not masked after select");
    a_busy_start: assert property ($rose(busy) |-> !$past(serial_clock) && !chip_select_n)
        else $error("Busy rose off a clock fall");
    a_busy_end: assert property ($fell(busy) |-> !$past(serial_clock))
        else $error("Busy fell off a clock fall");
    a_out_on_fall: assert property ($changed(serial_out) |-> !$past(serial_clock))
        else $error("Data changed off a clock fall");
    a_plates_paired: assert property (drv_x_high == drv_x_low && drv_y_high == drv_y_low)
        else $error("Plate drivers unpaired");
    a_one_plate: assert property (!(drv_x_high && drv_y_high))
        else $error("Both plates driven");
    c_busy: cover property ($rose(busy));
    c_pen: cover property ($rose(pen_touch_irq_n_oe));
    c_x_plate: cover property (drv_x_high && busy);
endmodule // tsq_serial_seq_assertions

bind tsq_serial_seq tsq_serial_seq_assertions u_chk (.mclk, .rst, .chip_select_n, .serial_clock,
    .pen_touched, .serial_out, .serial_out_oe, .busy, .busy_oe, .pen_touch_irq_n_o, .pen_touch_irq_n_oe,
    .drv_x_high, .drv_x_low, .drv_y_high, .drv_y_low, .adc_powered);

//--- pkg/tsq_map.vh
// Constants of the touch-screen serial sequencer: control byte layout, codes and counts
`ifndef TSQ_MAP_VH
`define TSQ_MAP_VH

// Control byte bit positions, first bit received is bit 7
`define TSQ_CTRL_START 7
`define TSQ_CTRL_ADDR_HI 6
`define TSQ_CTRL_ADDR_LO 4
`define TSQ_CTRL_RES8 3
`define TSQ_CTRL_REFSEL 2
`define TSQ_CTRL_PM_HI 1
`define TSQ_CTRL_PM_LO 0

// Channel address codes
`define TSQ_ADDR_Y 3'h1
`define TSQ_ADDR_X 3'h5
`define TSQ_ADDR_AUXA 3'h2
`define TSQ_ADDR_AUXB 3'h6

// Power mode codes
`define TSQ_PM_AUTO_OFF 2'h0
`define TSQ_PM_RESERVED 2'h2
`define TSQ_PM_RESET 2'h0

// Converter positive input selection codes
`define TSQ_SEL_NONE 3'h0
`define TSQ_SEL_XH 3'h1
`define TSQ_SEL_YH 3'h2
`define TSQ_SEL_AUXA 3'h3
`define TSQ_SEL_AUXB 3'h4

// Converter reference selection codes
`define TSQ_REF_EXT 2'h0
`define TSQ_REF_YPLATE 2'h1
`define TSQ_REF_XPLATE 2'h2

// Serial clock counts
`define TSQ_CTRL_BITS 4'h8
`define TSQ_ACQ_BIT 4'h5
`define TSQ_OVERLAP_BITS 4'h6
`define TSQ_BITS_12 4'hC
`define TSQ_BITS_8 4'h8

// Structure defaults
`define TSQ_SAR_W 12
`define TSQ_FIFO_DEPTH 4

`endif

//--- rtl/tsq_fifo.v
// Result FIFO with valid/ready on both sides and registered flags
`timescale 1ns/1ps
module tsq_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire mclk,
    input wire rst,
    input wire clk_en,
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
    reg [AW-1:0] wr_q; // Write pointer
    reg [AW-1:0] rd_q; // Read pointer
    reg [AW:0] cnt_q; // Occupancy
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    reg [AW:0] cnt_d;

    // Next occupancy
    always @* begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage write, no reset needed on data
    always @(posedge mclk) begin
        if (clk_en & push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and flags kept as flops so ready and valid are clean
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != DEPTH);
            out_valid <= (cnt_d != {(AW+1){1'b0}});
        end
    end

    assign out_data = mem[rd_q];
endmodule // tsq_fifo

//--- rtl/tsq_sar.v
// Successive-approximation register: one comparator decision per step
`timescale 1ns/1ps
module tsq_sar #(
    parameter W = 12
) (
    input wire mclk,
    input wire rst,
    input wire clk_en,
    input wire start,
    input wire step,
    input wire decision,
    output reg [W-1:0] trial,
    output reg [W-1:0] result
);
    reg [W-1:0] pos_q; // One-hot bit under test
    wire [W-1:0] res_next = result | (decision ? pos_q : {W{1'b0}});

    // Start loads mid-scale, each step keeps or drops the bit under test
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pos_q <= {W{1'b0}};
            trial <= {W{1'b0}};
            result <= {W{1'b0}};
        end else if (clk_en) begin
            if (start) begin
                pos_q <= {1'b1, {(W-1){1'b0}}};
                trial <= {1'b1, {(W-1){1'b0}}};
                result <= {W{1'b0}};
            end else if (step) begin
                pos_q <= pos_q >> 1;
                result <= res_next;
                trial <= res_next | (pos_q >> 1);
            end
        end
    end
endmodule // tsq_sar

//--- rtl/tsq_serial_seq.v
// Serial interface and conversion sequencer of a four-wire touch-screen converter
//
// Overview of operation
// [RULE1] Reference select 1 single-ended, 0 ratiometric
// [RULE2] Single-ended Y: sample X high, drive Y
// [RULE3] Single-ended: drivers off during conversion phase
// [RULE4] Ratiometric map: 001 Y plates, 101 X plates
// [RULE5] Ratiometric: drivers on acquisition through conversion
// [RULE6] Enabled pen interrupt pulls low while touched
// [RULE7] Host ignores pen interrupt after select falls
// [RULE8] Pen interrupt valid after last bit or deselect
// [RULE9] Deselected: interface ignored, outputs released
// [RULE10] Serial input shifted in on rising edges
// [RULE11] Leading zeros ignored; first one starts
// [RULE12] Conversion starts on fall after eighth bit
// [RULE13] Host is mode-0 master, 500kHz to 2MHz
// [RULE14] Host sends control byte then two zero bytes
// [RULE15] Twelve-bit result spans two bytes, four zeros follow
// [RULE16] Result straight binary, MSB first, on falls
// [RULE17] Busy one period, then 12 decisions out
// [RULE18] Host finishes each conversion within 500 us
// [RULE19] New start accepted after decision six
// [RULE20] Recognised start runs to completion unless deselected
// [RULE21] Host sends 16 zeros on tied-low select
// [RULE22] Eight-bit mode ends four clocks sooner
// [RULE23] Control byte: start, address, res, ref, power
// [RULE24] Single-ended address decode incl. two auxiliaries
// [RULE25] Pen interrupt enabled only in power mode 00
// [RULE26] Deselect aborts conversion and powers down
// [RULE27] Reserved addresses leave all drivers off
// [RULE28] One comparator decision per serial clock fall
`timescale 1ns/1ps
`include "tsq_map.vh"
module tsq_serial_seq #(
    parameter SAR_W = `TSQ_SAR_W,
    parameter FIFO_DEPTH = `TSQ_FIFO_DEPTH,
    parameter FIFO_AW = 2
) (
    input wire mclk,
    input wire rst,
    input wire clk_en,
    input wire chip_select_n,
    input wire serial_clock,
    input wire serial_in,
    input wire comp_above,
    input wire pen_touched,
    input wire result_ready,
    output reg serial_out,
    output reg serial_out_oe,
    output reg busy,
    output reg busy_oe,
    output reg pen_touch_irq_n_o,
    output reg pen_touch_irq_n_oe,
    output reg drv_x_high,
    output reg drv_x_low,
    output reg drv_y_high,
    output reg drv_y_low,
    output reg [2:0] adc_pos_sel,
    output reg [1:0] adc_ref_sel,
    output reg adc_powered,
    output reg sample_hold,
    output wire [SAR_W-1:0] sar_trial,
    output wire result_valid,
    output wire [SAR_W+3:0] result_data,
    output wire result_room,
    output reg result_dropped
);
    localparam RESULT_W = SAR_W + 4; // Resolution flag, address, result

    // Edge detection on the host clock, sampled as a synchronous input
    reg sclk_q; // Previous serial clock level
    reg cs_n_q; // Previous chip select level
    // Each edge is seen one mclk after the host moves
    wire sclk_rise = serial_clock & ~sclk_q;
    wire sclk_fall = ~serial_clock & sclk_q;
    wire cs_fall = cs_n_q & ~chip_select_n;

    // Control byte capture
    reg cap_active_q; // Start bit seen, collecting the byte
    reg [3:0] cap_cnt_q; // Control bits collected so far
    reg [7:0] ctrl_q; // Shift register, newest bit in bit 0
    reg [2:0] acq_addr_q; // Address used during acquisition
    reg acq_q; // Acquisition window open

    // Conversion state
    reg [7:0] conv_ctrl_q; // Control byte of the running conversion
    reg conv_active_q; // Conversion in progress
    reg [3:0] bit_cnt_q; // Decisions already presented
    reg pen_en_q; // Pen interrupt enabled by last power mode
    reg mask_q; // Pen interrupt masked during a transaction
    reg push_q; // Result write strobe to the FIFO
    reg [RESULT_W-1:0] push_data_q; // Result word to store
    // Sub-block results
    wire [SAR_W-1:0] sar_result;
    wire fifo_in_ready;

    // Fields of the running conversion
    wire [2:0] conv_addr = conv_ctrl_q[`TSQ_CTRL_ADDR_HI:`TSQ_CTRL_ADDR_LO];
    wire conv_res8 = conv_ctrl_q[`TSQ_CTRL_RES8];
    wire conv_single = conv_ctrl_q[`TSQ_CTRL_REFSEL];
    wire [1:0] conv_pm = conv_ctrl_q[`TSQ_CTRL_PM_HI:`TSQ_CTRL_PM_LO];
    wire [3:0] conv_bits = conv_res8 ? `TSQ_BITS_8 : `TSQ_BITS_12; // [RULE22]

    // New byte may start when idle or once six decisions are out
    // Earlier ones would collide with the running byte,
    // so they are not taken as start bits
    wire may_start = ~cap_active_q & (~conv_active_q | (~busy & (bit_cnt_q >= `TSQ_OVERLAP_BITS))); // [RULE19]
    // Eight bits in: the next fall launches the conversion
    // and closes acquisition
    wire cap_done = cap_active_q & (cap_cnt_q == `TSQ_CTRL_BITS);
    wire conv_start = sclk_fall & cap_done; // [RULE12]
    // Busy fall and every decision fall step the register
    wire conv_step = sclk_fall & ~cap_done & conv_active_q & (busy | (bit_cnt_q < conv_bits)); // [RULE28]
    // Fall after the last decision ends the conversion
    wire conv_end = sclk_fall & ~cap_done & conv_active_q & ~busy & (bit_cnt_q >= conv_bits);

    // Panel drivers for an address: {x_high, x_low, y_high, y_low}
    function [3:0] drv_decode;
        input [2:0] addr;
        begin
            // One layer biased, the other senses
            case (addr)
                `TSQ_ADDR_Y: drv_decode = 4'h3; // [RULE2]
                `TSQ_ADDR_X: drv_decode = 4'hC; // [RULE4]
                default: drv_decode = 4'h0; // [RULE27]
            endcase
        end
    endfunction

    // Converter positive input for an address and mode
    function [2:0] sel_decode;
        input [2:0] addr;
        input single;
        begin
            // Auxiliary inputs only in single-ended mode
            case (addr)
                `TSQ_ADDR_Y: sel_decode = `TSQ_SEL_XH; // [RULE24]
                `TSQ_ADDR_X: sel_decode = `TSQ_SEL_YH; // [RULE24]
                `TSQ_ADDR_AUXA: sel_decode = single ? `TSQ_SEL_AUXA : `TSQ_SEL_NONE; // [RULE24]
                `TSQ_ADDR_AUXB: sel_decode = single ? `TSQ_SEL_AUXB : `TSQ_SEL_NONE; // [RULE24]
                default: sel_decode = `TSQ_SEL_NONE; // [RULE27]
            endcase
        end
    endfunction

    // Analog switch settings, registered so every output is a flop
    // Decoded settings ahead of the output flops
    reg [3:0] drv_d;
    reg [2:0] sel_d;
    reg [1:0] ref_d;
    always @* begin
        // Default: all off, external reference
        drv_d = 4'h0;
        sel_d = `TSQ_SEL_NONE;
        ref_d = `TSQ_REF_EXT;
        if (acq_q) begin
            // Both modes bias the panel while the sample settles
            drv_d = drv_decode(acq_addr_q);
            sel_d = sel_decode(acq_addr_q, 1'b1);
        end else if (conv_active_q) begin
            sel_d = sel_decode(conv_addr, conv_single);
            if (conv_single) begin
                // Drivers off during conversion: saves panel current
                drv_d = 4'h0; // [RULE3]
                ref_d = `TSQ_REF_EXT; // [RULE1]
            end else begin
                drv_d = drv_decode(conv_addr); // [RULE5]
                case (conv_addr)
                    `TSQ_ADDR_Y: ref_d = `TSQ_REF_YPLATE; // [RULE4]
                    `TSQ_ADDR_X: ref_d = `TSQ_REF_XPLATE; // [RULE4]
                    default: ref_d = `TSQ_REF_EXT;
                endcase
            end
        end
    end

    // Serial protocol sequencer
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            cap_active_q <= 1'b0;
            cap_cnt_q <= 4'h0;
            ctrl_q <= 8'h00;
            acq_addr_q <= 3'h0;
            acq_q <= 1'b0;
            conv_ctrl_q <= 8'h00;
            conv_active_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            busy <= 1'b0;
            serial_out <= 1'b0;
            adc_powered <= 1'b0;
            // Pen armed out of reset, as mode 00
            pen_en_q <= 1'b1;
            mask_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= {RESULT_W{1'b0}};
        end else if (clk_en) begin
            sclk_q <= serial_clock;
            cs_n_q <= chip_select_n;
            // Write strobe lasts one mclk
            push_q <= 1'b0;
            if (chip_select_n) begin
                // Deselect: abort everything and power down
                cap_active_q <= 1'b0; // [RULE9]
                cap_cnt_q <= 4'h0;
                acq_q <= 1'b0;
                conv_active_q <= 1'b0; // [RULE26]
                busy <= 1'b0;
                bit_cnt_q <= 4'h0;
                serial_out <= 1'b0;
                adc_powered <= 1'b0; // [RULE26]
                mask_q <= 1'b0; // [RULE8]
            end else begin
                // Selected: the select fall and host clock edges drive all
                if (cs_fall) begin
                    // Channel switching may glitch the pen detector
                    mask_q <= 1'b1; // [RULE7]
                end
                // Rises take the serial input
                if (sclk_rise) begin
                    if (may_start & serial_in) begin
                        // First one after any zeros is the start bit
                        cap_active_q <= 1'b1; // [RULE11]
                        cap_cnt_q <= 4'h1;
                        ctrl_q <= {ctrl_q[6:0], serial_in}; // [RULE10]
                    end else if (cap_active_q & (cap_cnt_q < `TSQ_CTRL_BITS)) begin
                        // Ones after the start are plain bits
                        cap_cnt_q <= cap_cnt_q + 4'h1;
                        ctrl_q <= {ctrl_q[6:0], serial_in}; // [RULE10]
                    end
                end
                if (conv_start) begin
                    // Latch the byte and raise busy for one period
                    conv_ctrl_q <= ctrl_q; // [RULE23]
                    cap_active_q <= 1'b0;
                    cap_cnt_q <= 4'h0;
                    acq_q <= 1'b0;
                    conv_active_q <= 1'b1; // [RULE20]
                    busy <= 1'b1; // [RULE17]
                    bit_cnt_q <= 4'h0;
                    serial_out <= 1'b0;
                    adc_powered <= 1'b1;
                    // New power mode rules the pen line
                    pen_en_q <= (ctrl_q[`TSQ_CTRL_PM_HI:`TSQ_CTRL_PM_LO] == `TSQ_PM_AUTO_OFF); // [RULE25]
                end else begin
                    if (conv_step) begin
                        // Busy drops as the MSB decision appears
                        busy <= 1'b0; // [RULE17]
                        serial_out <= comp_above; // [RULE16]
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (conv_end) begin
                        // Trailing zeros follow the last decision
                        serial_out <= 1'b0; // [RULE15]
                        conv_active_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        mask_q <= 1'b0; // [RULE8]
                        // Mode 00 powers down between conversions,
                        // unless the next byte is arriving
                        adc_powered <= (conv_pm != `TSQ_PM_AUTO_OFF) | cap_active_q;
                        push_q <= 1'b1;
                        // Flag, address, then the code
                        push_data_q <= {conv_res8, conv_addr, sar_result};
                    end
                    if (sclk_fall & cap_active_q & (cap_cnt_q == `TSQ_ACQ_BIT)) begin
                        // Acquisition opens once the address is known
                        acq_q <= 1'b1;
                        acq_addr_q <= ctrl_q[3:1];
                        adc_powered <= 1'b1;
                    end
                end
            end
        end
    end

    // Output enables, switches and pen interrupt
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_out_oe <= 1'b0;
            busy_oe <= 1'b0;
            pen_touch_irq_n_o <= 1'b0;
            pen_touch_irq_n_oe <= 1'b0;
            drv_x_high <= 1'b0;
            drv_x_low <= 1'b0;
            drv_y_high <= 1'b0;
            drv_y_low <= 1'b0;
            adc_pos_sel <= `TSQ_SEL_NONE;
            adc_ref_sel <= `TSQ_REF_EXT;
            sample_hold <= 1'b0;
            result_dropped <= 1'b0;
        end else if (clk_en) begin
            // Release trails chip select by one mclk
            serial_out_oe <= ~chip_select_n; // [RULE9]
            busy_oe <= ~chip_select_n; // [RULE9]
            pen_touch_irq_n_o <= 1'b0;
            // Open drain: enable means pulling the line low
            pen_touch_irq_n_oe <= pen_en_q & pen_touched & ~mask_q & ~cs_fall; // [RULE6]
            // Switches follow the decode one mclk late
            {drv_x_high, drv_x_low, drv_y_high, drv_y_low} <= drv_d;
            adc_pos_sel <= sel_d;
            adc_ref_sel <= ref_d;
            // Hold switch marks the acquisition window
            sample_hold <= acq_q;
            // Host clock cannot be stalled, so a full FIFO loses the word
            result_dropped <= push_q & ~fifo_in_ready;
        end
    end

    // Approximation register driven from the serial clock falls
    // Gated by select so an abort freezes it
    tsq_sar #(
        .W(SAR_W)
    ) u_sar (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .start(conv_start & ~chip_select_n),
        .step(conv_step & ~chip_select_n),
        .decision(comp_above),
        .trial(sar_trial),
        .result(sar_result)
    );

    // Completed results queue for the local consumer
    tsq_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );

    // Room flag shows back-pressure to the consumer
    assign result_room = fifo_in_ready;
endmodule // tsq_serial_seq
